// File: logic/lac_abort_classifier.sv
`timescale 1ns/100ps
// Function
// RULE_01: Fetch faults: protection, bus errors, breakpoint, vector
// RULE_02: Data faults: protection incl. alignment, bus errors, watchpoint
// RULE_03: Protection aborts always reported synchronously
// RULE_04: Protection abort wins over other causes; a data one loses to any fetch-side abort
// RULE_05: Protection fault on uncached miss blocks bus
// RULE_06: Slave and decode errors both external errors
// RULE_07: Fetch external error gives synchronous abort
// RULE_08: Load/store external error gives asynchronous abort
// RULE_09: Debug events on fetches and data accesses
// RULE_10: Monitor mode aborts on debug event, breakpoint instruction
// RULE_11: Synchronous abort taken on faulting instruction
// RULE_12: Link register and saved status captured
// RULE_13: One protection unit checks both sides
// RULE_14: Masked asynchronous abort held pending until unmask
// RULE_15: Only one pending asynchronous abort kept
// RULE_16: Mask set on reset, abort, interrupts
// RULE_17: Fault address recorded for synchronous aborts
// RULE_18: Each taken abort carries a cause code
module lac_abort_classifier
   import lac_pkg::*;
(
   input  wire logic              CLOCK,          // Core clock, 25 MHz
   input  wire logic              SYS_RST,        // Synchronous reset, active high
   // Instruction side, one access per valid cycle
   input  wire logic              IF_VALID,       // Fetch access resolves this cycle
   input  wire logic [ADDR_W-1:0] IF_ADDR,        // Fetch address
   input  wire logic [ADDR_W-1:0] IF_PC,          // Address of fetched instruction
   input  wire logic              IF_LOCAL_HIT,   // Fetch served by TCM or cache hit
   input  wire logic [1:0]        IF_RESP,        // Bus response for the fetch
   input  wire logic              IF_RESP_VALID,  // Bus response present
   input  wire logic              IF_SOFTWARE_BREAKPOINT_INSTRUCTION_HIT,    // Breakpoint matched
   input  wire logic              IF_VCAP_HIT,    // Vector capture matched
   input  wire logic              IF_SW_SOFTWARE_BREAKPOINT_INSTRUCTION,     // Software breakpoint instruction
   // Data side
   input  wire logic              D_VALID,        // Data access resolves this cycle
   input  wire logic [ADDR_W-1:0] D_ADDR,         // Data address
   input  wire logic [ADDR_W-1:0] D_PC,           // Address of load/store instruction
   input  wire logic              D_LOCAL_HIT,    // Access served by TCM or cache hit
   input  wire logic              D_ALIGN_ERR,    // Misaligned access
   input  wire logic              D_WPT_HIT,      // Watchpoint matched
   input  wire logic [1:0]        D_BRESP,        // Late response of any load/store
   input  wire logic              D_BRESP_VALID,  // Late response present
   // Unified protection unit verdicts
   input  wire logic              PROT_IF_BG,     // Fetch hits no region
   input  wire logic              PROT_IF_PERM,   // Fetch lacks permission
   input  wire logic              PROT_D_BG,      // Data hits no region
   input  wire logic              PROT_D_PERM,    // Data lacks permission
   // Core state
   input  wire logic              MONITOR_MODE,   // Monitor-mode debugging selected
   input  wire logic [PSR_W-1:0]  CUR_PSR,        // Current status word
   input  wire logic              IRQ_TAKEN,      // Normal interrupt taken
   input  wire logic              FIQ_TAKEN,      // Fast interrupt taken
   input  wire logic              A_MASK_CLR,     // Software clears abort mask
   // Results
   output logic                   IF_BUS_EN,      // Fetch may go to the bus
   output logic                   D_BUS_EN,       // Data access may go to the bus
   output logic                   ABORT_TAKEN,    // One-cycle abort pulse
   output logic                   ABORT_SYNC,     // Taken abort is synchronous
   output logic                   ABORT_IS_FETCH, // Taken abort is on the fetch side
   output lac_cause_t             ABORT_CAUSE,    // Cause code
   output logic [ADDR_W-1:0]      ABORT_LINK,     // abort_link_register
   output logic [PSR_W-1:0]       ABORT_SAVED_PSR,// abort_saved_status
   output logic [ADDR_W-1:0]      FETCH_FAULT_ADDR, // fetch_fault_address
   output logic [ADDR_W-1:0]      DATA_FAULT_ADDR,  // data_fault_address
   output logic                   A_MASK,         // Asynchronous abort mask
   output logic                   ASYNC_PENDING   // Asynchronous abort waiting
);

   // External error test shared by both sides
   function automatic logic is_ext_err(input logic [1:0] resp);
      is_ext_err = (resp == RESP_SLVERR) || (resp == RESP_DECERR); // RULE_06
   endfunction

   // Protection verdicts from the single unit, split by side
   wire if_prot   = IF_VALID && (PROT_IF_BG || PROT_IF_PERM);               // RULE_13
   wire d_prot    = D_VALID && (PROT_D_BG || PROT_D_PERM || D_ALIGN_ERR);   // RULE_13
   // Bus errors per side
   wire if_ext    = IF_VALID && IF_RESP_VALID && is_ext_err(IF_RESP);       // RULE_01
   wire d_ext     = D_BRESP_VALID && is_ext_err(D_BRESP);                   // RULE_02
   // Debug events only abort in monitor mode
   wire if_dbg    = IF_VALID && MONITOR_MODE
                    && (IF_SOFTWARE_BREAKPOINT_INSTRUCTION_HIT || IF_VCAP_HIT || IF_SW_SOFTWARE_BREAKPOINT_INSTRUCTION);          // RULE_09
   wire d_dbg     = D_VALID && MONITOR_MODE && D_WPT_HIT;                   // RULE_10
   // Synchronous candidates, fetch side ahead of data side
   wire if_sync   = if_prot || if_ext || if_dbg;                            // RULE_07
   wire d_sync    = d_prot || d_dbg;                                        // RULE_03
   wire any_sync  = if_sync || d_sync;

   // Protection cause per side; background outranks permission outranks alignment
   wire lac_cause_t if_pcause = PROT_IF_BG ? CAUSE_PROT_BG : CAUSE_PROT_PERM;
   wire lac_cause_t d_pcause  = PROT_D_BG ? CAUSE_PROT_BG :
                                PROT_D_PERM ? CAUSE_PROT_PERM : CAUSE_PROT_ALGN;
   // Protection before bus error before debug
   wire lac_cause_t if_cause  = if_prot ? if_pcause :                       // RULE_04
                                if_ext ? CAUSE_SYNC_EXT : CAUSE_DEBUG;
   wire lac_cause_t d_cause   = d_prot ? d_pcause : CAUSE_DEBUG;            // RULE_04

   // Pending asynchronous abort may fire when unmasked and no sync abort
   wire mask_now  = A_MASK && !A_MASK_CLR;
   wire async_go  = (ASYNC_PENDING || d_ext) && !mask_now && !any_sync;     // RULE_14
   wire take      = any_sync || async_go;
   wire sync_fetch = if_sync;

   // Bus suppression: a rejected miss never leaves the core
   wire nxt_if_bus = IF_VALID && !IF_LOCAL_HIT && !if_prot;                 // RULE_05
   wire nxt_d_bus  = D_VALID && !D_LOCAL_HIT && !d_prot;                    // RULE_05

   // Bus enables registered so every output comes from a flop
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         IF_BUS_EN <= 1'b0;
         D_BUS_EN  <= 1'b0;
      end else begin
         IF_BUS_EN <= nxt_if_bus;
         D_BUS_EN  <= nxt_d_bus;
      end
   end

   // Abort report; the sync pick uses the faulting instruction's own PC
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         ABORT_TAKEN     <= 1'b0;
         ABORT_SYNC      <= 1'b0;
         ABORT_IS_FETCH  <= 1'b0;
         ABORT_CAUSE     <= CAUSE_NONE;
         ABORT_LINK      <= ADDR_RST;
         ABORT_SAVED_PSR <= PSR_RST;
      end else begin
         ABORT_TAKEN <= take;                                              // RULE_18
         if (take) begin
            ABORT_SYNC      <= any_sync;                                   // RULE_11
            ABORT_IS_FETCH  <= sync_fetch;
            ABORT_CAUSE     <= sync_fetch ? if_cause :
                               d_sync ? d_cause : CAUSE_ASYNC_EXT;         // RULE_18
            // Async aborts land on whatever instruction is current
            ABORT_LINK      <= sync_fetch ? IF_PC : D_PC;                  // RULE_12
            ABORT_SAVED_PSR <= CUR_PSR;                                    // RULE_12
         end
      end
   end

   // Fault addresses only move on synchronous aborts of their own side
   // A data address hidden behind a fetch abort is lost, as that abort is not taken
   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         FETCH_FAULT_ADDR <= ADDR_RST;
         DATA_FAULT_ADDR  <= ADDR_RST;
      end else begin
         if (sync_fetch) begin
            FETCH_FAULT_ADDR <= IF_ADDR;                                   // RULE_17
         end else if (d_sync) begin
            DATA_FAULT_ADDR  <= D_ADDR;                                    // RULE_17
         end
      end
   end

   // Mask set on reset and any taken exception; the set wins over a clear
   wire nxt_mask = take || IRQ_TAKEN || FIQ_TAKEN || mask_now;            // RULE_16
   // One pending slot; a second error while pending is dropped
   wire nxt_pend = async_go ? 1'b0 : (ASYNC_PENDING || d_ext);            // RULE_15

   always_ff @(posedge CLOCK) begin
      if (SYS_RST) begin
         A_MASK        <= 1'b1;                                            // RULE_16
         ASYNC_PENDING <= 1'b0;
      end else begin
         A_MASK        <= nxt_mask;
         ASYNC_PENDING <= nxt_pend;                                        // RULE_08
      end
   end

   // Checks
   chk_prot_wins: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      if_prot |=> ABORT_TAKEN && ABORT_SYNC && ABORT_IS_FETCH
                  && ABORT_CAUSE inside {CAUSE_PROT_BG, CAUSE_PROT_PERM}) // RULE_04
      else $error("fetch protection abort not reported first");
   chk_bus_block: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      d_prot |=> !D_BUS_EN) // RULE_05
      else $error("rejected access reached the bus");
   chk_bus_gate: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      if_prot |=> !IF_BUS_EN) // RULE_05
      else $error("rejected fetch reached the bus");
   chk_fetch_ext: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (if_ext && !if_prot) |=> ABORT_CAUSE == CAUSE_SYNC_EXT && ABORT_LINK == $past(IF_PC))
      else $error("fetch bus error not synchronous"); // RULE_07
   chk_data_async: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (d_ext && !ASYNC_PENDING && !any_sync && mask_now) |=> ASYNC_PENDING && !ABORT_TAKEN)
      else $error("data bus error not held pending"); // RULE_08
   chk_mask_hold: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (ASYNC_PENDING && A_MASK && !A_MASK_CLR) |=> ASYNC_PENDING)
      else $error("pending abort lost while masked"); // RULE_14
   chk_mask_set: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (IRQ_TAKEN || FIQ_TAKEN) |=> A_MASK)
      else $error("mask not set by exception"); // RULE_16
   chk_async_take: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      async_go |=> ABORT_TAKEN && !ABORT_SYNC && ABORT_CAUSE == CAUSE_ASYNC_EXT && A_MASK)
      else $error("asynchronous abort not taken"); // RULE_15
   chk_far_data: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (d_sync && !if_sync) |=> DATA_FAULT_ADDR == $past(D_ADDR))
      else $error("data fault address not recorded"); // RULE_17
   chk_dbg_mon: assert property (@(posedge CLOCK) disable iff (SYS_RST)
      (IF_VALID && IF_SW_SOFTWARE_BREAKPOINT_INSTRUCTION && !MONITOR_MODE && !if_prot && !if_ext
       && !d_sync && !async_go) |=> !ABORT_TAKEN)
      else $error("breakpoint abort outside monitor mode"); // RULE_10

   // Reset leaves the mask set and nothing pending
   chk_reset_state: assert property (@(posedge CLOCK) // RULE_16
      SYS_RST |=> A_MASK && !ASYNC_PENDING && !ABORT_TAKEN)
      else $error("reset state wrong");
   // Data protection faults are synchronous on the data side
   chk_data_prot: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_03
      (d_prot && !if_sync) |=> ABORT_TAKEN && ABORT_SYNC && !ABORT_IS_FETCH)
      else $error("data protection abort not synchronous");
   // Clean data miss may use the bus
   chk_dbus_pass: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_05
      (D_VALID && !D_LOCAL_HIT && !d_prot) |=> D_BUS_EN)
      else $error("clean data miss kept off the bus");
   // Clean fetch miss may use the bus
   chk_ibus_pass: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_05
      (IF_VALID && !IF_LOCAL_HIT && !if_prot) |=> IF_BUS_EN)
      else $error("clean fetch miss kept off the bus");
   // Local fetch hits never need the bus
   chk_local_quiet: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_05
      (IF_VALID && IF_LOCAL_HIT) |=> !IF_BUS_EN)
      else $error("local fetch hit went to the bus");
   // Decode error on a fetch is an external error
   chk_decode_err: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_06
      (IF_VALID && IF_RESP_VALID && IF_RESP == RESP_DECERR && !if_prot)
      |=> ABORT_TAKEN && ABORT_CAUSE == CAUSE_SYNC_EXT)
      else $error("decode error not treated as external");
   // Slave error on a fetch is an external error
   chk_slave_err: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_06
      (IF_VALID && IF_RESP_VALID && IF_RESP == RESP_SLVERR && !if_prot)
      |=> ABORT_TAKEN && ABORT_CAUSE == CAUSE_SYNC_EXT)
      else $error("slave error not treated as external");
   // Fetch abort lands on the fetched instruction
   chk_fetch_link: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_11
      if_sync |=> ABORT_IS_FETCH && ABORT_LINK == $past(IF_PC))
      else $error("fetch abort on wrong instruction");
   // Data sync abort lands on the load or store itself
   chk_data_link: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_11
      (d_sync && !if_sync) |=> ABORT_LINK == $past(D_PC))
      else $error("data abort on wrong instruction");
   // Status word captured at the abort
   chk_saved_psr: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_12
      take |=> ABORT_SAVED_PSR == $past(CUR_PSR))
      else $error("saved status not captured");
   // Fetch fault address recorded
   chk_far_fetch: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_17
      if_sync |=> FETCH_FAULT_ADDR == $past(IF_ADDR))
      else $error("fetch fault address not recorded");
   // A synchronous external abort only ever comes from a fetch
   chk_ext_fetch_only: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_08
      (ABORT_TAKEN && ABORT_CAUSE == CAUSE_SYNC_EXT) |-> ABORT_IS_FETCH)
      else $error("data bus error reported synchronously");
   // An asynchronous abort is never taken while masked
   chk_async_unmasked: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_14
      (ABORT_TAKEN && !ABORT_SYNC) |-> !$past(mask_now))
      else $error("asynchronous abort taken while masked");
   // Taking the pending abort empties the single slot
   chk_pend_clear: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_15
      async_go |=> !ASYNC_PENDING)
      else $error("second asynchronous abort kept");
   // A sync abort goes first and the pending one waits
   chk_sync_ahead: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_11
      (any_sync && ASYNC_PENDING) |=> ABORT_SYNC && ASYNC_PENDING)
      else $error("pending abort overtook a synchronous one");
   // Any taken abort sets the mask
   chk_mask_abort: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_16
      take |=> A_MASK)
      else $error("mask not set by abort");
   // A taken abort always carries a cause
   chk_cause_set: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_18
      ABORT_TAKEN |-> ABORT_CAUSE != CAUSE_NONE)
      else $error("abort without cause code");
   // No cause, no abort pulse
   chk_no_cause: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_18
      (!any_sync && !async_go) |=> !ABORT_TAKEN)
      else $error("abort pulse without cause");
   // Fetch debug events abort in monitor mode
   chk_fetch_dbg: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_09
      (if_dbg && !if_prot && !if_ext) |=> ABORT_IS_FETCH && ABORT_CAUSE == CAUSE_DEBUG)
      else $error("fetch debug event not aborted");
   // Watchpoint aborts in monitor mode
   chk_wpt_abort: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_10
      (d_dbg && !d_prot && !if_sync) |=> ABORT_TAKEN && ABORT_CAUSE == CAUSE_DEBUG)
      else $error("watchpoint not aborted");
   // Data background verdict from the shared unit
   chk_data_bg: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_13
      (D_VALID && PROT_D_BG && !if_sync) |=> ABORT_CAUSE == CAUSE_PROT_BG)
      else $error("data background fault lost");
   // Fetch side wins over data side
   chk_fetch_first: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_01
      (if_sync && d_sync) |=> ABORT_IS_FETCH)
      else $error("data abort beat fetch abort");
   // Alignment fault alone gives its own cause
   chk_align_cause: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_02
      (D_VALID && D_ALIGN_ERR && !PROT_D_BG && !PROT_D_PERM && !if_sync)
      |=> ABORT_CAUSE == CAUSE_PROT_ALGN)
      else $error("alignment fault cause wrong");
   // Protection outranks a coincident bus error on a fetch
   chk_prot_over_ext: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_04
      (if_prot && if_ext) |=> ABORT_CAUSE != CAUSE_SYNC_EXT)
      else $error("bus error beat protection fault");
   // Fetch bus errors are never deferred
   chk_ext_sync: assert property (@(posedge CLOCK) disable iff (SYS_RST) // RULE_07
      (if_ext && !if_prot) |=> ABORT_SYNC)
      else $error("fetch bus error deferred");

endmodule // lac_abort_classifier

// File: shared/lac_pkg.sv
package lac_pkg;
   // Widths
   localparam int ADDR_W  = 32;
   localparam int PSR_W   = 32;
   // Position of the asynchronous-abort mask in the status word
   localparam int PSR_A_BIT = 8;
   // Reset values
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
   localparam logic [PSR_W-1:0]  PSR_RST  = 32'h0000_0000;
   // Bus response encodings
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_EXOKAY = 2'h1;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   // Cause codes handed to the fault status logic
   typedef enum logic [2:0] {
      CAUSE_NONE      = 3'b000,
      CAUSE_PROT_BG   = 3'b001,
      CAUSE_PROT_PERM = 3'b010,
      CAUSE_PROT_ALGN = 3'b011,
      CAUSE_SYNC_EXT  = 3'b100,
      CAUSE_ASYNC_EXT = 3'b101,
      CAUSE_DEBUG     = 3'b110
   } lac_cause_t;
endpackage

// File: bench/lac_bus_model.sv
`timescale 1ns/100ps
// Far-side bus model: answers with the error code the bench asks for
module lac_bus_model
   import lac_pkg::*;
(
   input  wire logic       clk,     // Core clock
   input  wire logic [1:0] if_cmd,  // Fetch response to return
   input  wire logic       if_go,   // Return the fetch response now
   input  wire logic [1:0] d_cmd,   // Late data response to return
   input  wire logic       d_go,    // Return the data response now
   output logic [1:0]      if_resp, // Fetch response lines
   output logic            if_rv,   // Fetch response valid
   output logic [1:0]      d_resp,  // Data response lines
   output logic            d_rv     // Data response valid
);
   logic [1:0] junk_ff = 2'h1;
   // Idle lines change every cycle, so a stale code never looks like an answer
   always_ff @(posedge clk) begin
      junk_ff <= junk_ff + 2'h1;
   end
   // Slave and decode errors are both legal answers from the far side
   assign if_resp = if_go ? if_cmd : junk_ff;
   assign if_rv   = if_go;
   assign d_resp  = d_go ? d_cmd : ~junk_ff;
   assign d_rv    = d_go;
endmodule // lac_bus_model

// File: bench/lac_abort_classifier_bench.sv
`timescale 1ns/100ps
module lac_abort_classifier_bench
   import lac_pkg::*;
;
   logic        clock = 1'b0, sys_rst = 1'b1, mon, irq, fiq, a_clr, if_go, d_go, if_rv, d_rv;
   logic        if_valid, if_lhit, if_software_breakpoint_instruction, if_vcap, if_swb, d_valid, d_lhit, d_align, d_wpt;
   logic        p_if_bg, p_if_perm, p_d_bg, p_d_perm, if_bus_en, d_bus_en, ab_taken, ab_sync;
   logic        ab_fetch, a_mask, a_pend;
   logic [1:0]  if_cmd, d_cmd, if_resp, d_resp;
   logic [31:0] if_addr, if_pc, d_addr, d_pc, cur_psr, ab_link, ab_psr, f_faddr, d_faddr;
   lac_cause_t  ab_cause;
   int          bad_count = 0, total_checks = 0;
   // Core clock, 40 ns period
   always #20 clock = ~clock;
   lac_bus_model bus (.clk(clock), .if_cmd(if_cmd), .if_go(if_go), .d_cmd(d_cmd), .d_go(d_go),
      .if_resp(if_resp), .if_rv(if_rv), .d_resp(d_resp), .d_rv(d_rv));
   lac_abort_classifier dut (.CLOCK(clock), .SYS_RST(sys_rst), .IF_VALID(if_valid),
      .IF_ADDR(if_addr), .IF_PC(if_pc), .IF_LOCAL_HIT(if_lhit), .IF_RESP(if_resp),
      .IF_RESP_VALID(if_rv), .IF_SOFTWARE_BREAKPOINT_INSTRUCTION_HIT(if_software_breakpoint_instruction), .IF_VCAP_HIT(if_vcap), .IF_SW_SOFTWARE_BREAKPOINT_INSTRUCTION(if_swb),
      .D_VALID(d_valid), .D_ADDR(d_addr), .D_PC(d_pc), .D_LOCAL_HIT(d_lhit),
      .D_ALIGN_ERR(d_align), .D_WPT_HIT(d_wpt), .D_BRESP(d_resp), .D_BRESP_VALID(d_rv),
      .PROT_IF_BG(p_if_bg), .PROT_IF_PERM(p_if_perm), .PROT_D_BG(p_d_bg), .PROT_D_PERM(p_d_perm),
      .MONITOR_MODE(mon), .CUR_PSR(cur_psr), .IRQ_TAKEN(irq), .FIQ_TAKEN(fiq),
      .A_MASK_CLR(a_clr), .IF_BUS_EN(if_bus_en), .D_BUS_EN(d_bus_en), .ABORT_TAKEN(ab_taken),
      .ABORT_SYNC(ab_sync), .ABORT_IS_FETCH(ab_fetch), .ABORT_CAUSE(ab_cause),
      .ABORT_LINK(ab_link), .ABORT_SAVED_PSR(ab_psr), .FETCH_FAULT_ADDR(f_faddr),
      .DATA_FAULT_ADDR(d_faddr), .A_MASK(a_mask), .ASYNC_PENDING(a_pend));
   // One edge, then let its updates land before anything is looked at
   task automatic step();
      @(posedge clock);
      #1;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic idle();
      {if_valid, if_lhit, if_software_breakpoint_instruction, if_vcap, if_swb, d_valid, d_lhit, d_align, d_wpt} = '0;
      {p_if_bg, p_if_perm, p_d_bg, p_d_perm, irq, fiq, a_clr, if_go, d_go} = '0;
   endtask
   // Judges a synchronous abort one cycle after its cause
   task automatic sync_ab(input logic fe, input logic [31:0] cause, input logic [31:0] adr);
      chk(ab_taken, 1'b1);
      chk(ab_sync, 1'b1);
      chk(ab_fetch, fe);
      chk(ab_cause, cause);
      chk(ab_link, fe ? if_pc : d_pc);
      chk(ab_psr, cur_psr);
      chk(fe ? f_faddr : d_faddr, adr);
   endtask
   // Fetch protection faults beat a coincident bus error, with a breakpoint hit outside monitor mode, and block the bus
   task automatic t_fetch_prot();
      for (int i = 0; i < 2; i++) begin
         {if_valid, p_if_bg, p_if_perm, if_go, if_software_breakpoint_instruction} = {1'b1, i == 0, i == 1, 2'h3};
         if_cmd = RESP_SLVERR;
         step();
         idle();
         sync_ab(1'b1, (i == 0) ? CAUSE_PROT_BG : CAUSE_PROT_PERM, if_addr);
         chk(if_bus_en, 1'b0);
      end
   endtask
   // Both bus error codes on a fetch give a synchronous external abort
   task automatic t_fetch_ext();
      for (int i = 0; i < 2; i++) begin
         {if_valid, if_go, if_cmd} = {2'h3, (i == 0) ? RESP_SLVERR : RESP_DECERR};
         step();
         idle();
         sync_ab(1'b1, CAUSE_SYNC_EXT, if_addr);
         chk(if_bus_en, 1'b1);
      end
   endtask
   // Data-side protection faults, one with a watchpoint alongside
   task automatic t_data_prot();
      {d_valid, d_align} = 2'h3;
      step();
      idle();
      sync_ab(1'b0, CAUSE_PROT_ALGN, d_addr);
      {d_valid, p_d_perm, d_wpt} = 3'h7;
      step();
      idle();
      sync_ab(1'b0, CAUSE_PROT_PERM, d_addr);
      chk(d_bus_en, 1'b0);
   endtask
   // Each debug event and the breakpoint instruction abort in monitor mode
   task automatic t_debug();
      mon = 1'b1;
      for (int k = 0; k < 4; k++) begin
         {if_software_breakpoint_instruction, if_vcap, if_swb, d_wpt} = 4'h8 >> k;
         {if_valid, d_valid} = {k < 3, k == 3};
         if_lhit = 1'b1;
         step();
         idle();
         sync_ab(k < 3, CAUSE_DEBUG, (k < 3) ? if_addr : d_addr);
         chk({if_bus_en, d_bus_en}, {1'b0, k == 3});
      end
      mon = 1'b0;
      {if_valid, if_swb, if_lhit} = 3'h7;
      step();
      idle();
      chk(ab_taken, 1'b0);
   endtask
   // Masked data errors: one held pending, the second dropped, mask set again on take
   task automatic t_async();
      {d_go, d_cmd} = {1'b1, RESP_SLVERR};
      step();
      chk(a_pend, 1'b1);
      d_cmd = RESP_DECERR;
      step();
      idle();
      chk(ab_taken, 1'b0);
      a_clr = 1'b1;
      step();
      idle();
      chk({ab_taken, ab_sync, a_pend, a_mask}, 4'h9);
      chk(ab_cause, CAUSE_ASYNC_EXT);
      a_clr = 1'b1;
      step();
      idle();
      chk({ab_taken, a_pend, a_mask}, 3'h0);
      irq = 1'b1;
      step();
      fiq = 1'b1;
      chk(a_mask, 1'b1);
      step();
      idle();
      chk(a_mask, 1'b1);
   endtask
   task automatic results();
      if (bad_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Watchdog: the tests need well under a hundred cycles
   initial begin
      #(40 * 400);
      bad_count++;
      results();
   end
   initial begin
      idle();
      {mon, if_cmd, d_cmd, cur_psr} = {5'h0, 32'h0000_01d3};
      {if_addr, if_pc, d_addr, d_pc} = {32'h0000_4a10, 32'h0000_4a10, 32'h2000_0f02, 32'h0000_5c08};
      repeat (6) @(posedge clock);
      #1;
      sys_rst = 1'b0;
      chk({a_mask, ab_taken, a_pend}, 3'h4);
      t_fetch_prot();
      t_fetch_ext();
      t_data_prot();
      t_debug();
      t_async();
      results();
   end
endmodule // lac_abort_classifier_bench
